// ---- hw/bit_sync.sv ----
// Two-flop synchroniser for levels arriving from outside the clock domain.
// Assumes each bit is a slow level; no bundle coherence is promised.
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;
  sync_t r;
  sync_t r_nxt;
  always_comb begin
    r_nxt = r;
    r_nxt.s1 = d;
    r_nxt.s2 = r.s1;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '1;
    end else begin
      r <= r_nxt;
    end
  end
  assign q = r.s2;
endmodule
`default_nettype wire

// ---- hw/mag_device.sv ----
// Device end: two-wire slave, register pointer, measurement sequencer.
// Assumes the host never stretches or glitches the clock and the strap is static.
`timescale 1ns/1ps
`default_nettype none
module mag_device
  import mag_pkg::*;
#(
  parameter int MEAS_CYC = MEAS_AXIS_CYC
) (
  input wire logic clk,
  input wire logic rst,
  mag_link_if.dev link,
  input wire logic [2:0] addr_lo,
  input wire logic [15:0] x_field,
  input wire logic [15:0] y_field,
  input wire logic [15:0] z_field,
  output logic meas_active,
  output logic meas_done
);
  typedef enum logic [4:0] {
    D_IDLE = 5'b00001,
    D_RX = 5'b00010,
    D_ACK = 5'b00100,
    D_TX = 5'b01000,
    D_MACK = 5'b10000
  } dstate_t;

  typedef struct packed {
    dstate_t st;
    logic is_addr;
    logic is_ptr;
    logic rw;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic oe_n;
    logic ack_ok;
    logic scl_q;
    logic sda_q;
    logic [5:0][7:0] res;
    logic done;
    logic busy;
    logic [1:0] axis;
    logic [23:0] tmr;
  } dev_t;

  dev_t r;
  dev_t r_nxt;
  logic scl_s;
  logic sda_s;
  logic [2:0] adr_s;

  bit_sync #(.W(5)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({link.scl, link.sda, addr_lo}),
    .q({scl_s, sda_s, adr_s})
  );

  function automatic logic [7:0] rd_reg(input dev_t s, input logic [7:0] p);
    logic [7:0] v;
    v = 8'h00;
    if (p < REG_STATUS) begin
      v = s.res[p[2:0]];
    end else if (p == REG_STATUS) begin
      v[BIT_DONE] = s.done;
    end
    return v;
  endfunction

  logic sr;
  logic sf;
  logic start_c;
  logic stop_c;
  logic trig;
  logic [7:0] nb;

  assign sr = scl_s & ~r.scl_q;
  assign sf = ~scl_s & r.scl_q;
  assign start_c = r.scl_q & scl_s & r.sda_q & ~sda_s; // see [RL1]
  assign stop_c = r.scl_q & scl_s & ~r.sda_q & sda_s; // see [RL2]

  always_comb begin
    r_nxt = r;
    trig = 1'b0;
    nb = 8'h00;
    r_nxt.scl_q = scl_s;
    r_nxt.sda_q = sda_s;
    if (stop_c) begin
      r_nxt.st = D_IDLE; // see [RL11]
      r_nxt.oe_n = 1'b1;
    end else if (start_c) begin
      r_nxt.st = D_RX; // see [RL11]
      r_nxt.is_addr = 1'b1;
      r_nxt.is_ptr = 1'b0;
      r_nxt.cnt = 4'h0;
      r_nxt.oe_n = 1'b1;
    end else begin
      unique case (r.st)
        D_IDLE: begin
          r_nxt.oe_n = 1'b1; // see [RL18]
        end
        D_RX: begin
          if (sr) begin
            r_nxt.sh = {r.sh[6:0], sda_s}; // see [RL4]
            r_nxt.cnt = r.cnt + 4'h1;
          end
          if (sf && r.cnt == 4'h8) begin
            r_nxt.cnt = 4'h0;
            r_nxt.is_addr = 1'b0;
            r_nxt.st = D_ACK;
            r_nxt.oe_n = 1'b0; // see [RL7]
            if (r.is_addr) begin
              if (r.sh[7:1] == {DEV_ADDR_HI, adr_s}) begin // see [RL6]
                r_nxt.rw = r.sh[0]; // see [RL5]
                r_nxt.is_ptr = ~r.sh[0];
              end else begin
                r_nxt.st = D_IDLE; // see [RL18]
                r_nxt.oe_n = 1'b1;
              end
            end else if (r.is_ptr) begin
              r_nxt.ptr = r.sh; // see [RL8]
              r_nxt.is_ptr = 1'b0;
            end else begin
              trig = (r.ptr == REG_CONTROL) && r.sh[BIT_TRIGGER]; // see [RL12]
              r_nxt.ptr = r.ptr + 8'h01; // see [RL10]
            end
          end
        end
        D_ACK: begin
          if (sf) begin
            r_nxt.cnt = 4'h0;
            if (r.rw) begin
              nb = rd_reg(r, r.ptr); // see [RL19]
              r_nxt.sh = nb;
              r_nxt.ptr = r.ptr + 8'h01; // see [RL10]
              r_nxt.oe_n = nb[7]; // see [RL4]
              r_nxt.st = D_TX; // see [RL9]
            end else begin
              r_nxt.oe_n = 1'b1;
              r_nxt.st = D_RX; // see [RL9]
            end
          end
        end
        D_TX: begin
          if (sf) begin
            if (r.cnt == 4'h7) begin
              r_nxt.oe_n = 1'b1; // see [RL3]
              r_nxt.st = D_MACK;
            end else begin
              r_nxt.sh = {r.sh[6:0], 1'b0};
              r_nxt.oe_n = r.sh[6];
              r_nxt.cnt = r.cnt + 4'h1;
            end
          end
        end
        D_MACK: begin
          if (sr) begin
            r_nxt.ack_ok = ~sda_s;
          end
          if (sf) begin
            r_nxt.cnt = 4'h0;
            if (r.ack_ok) begin
              nb = rd_reg(r, r.ptr); // see [RL14]
              r_nxt.sh = nb;
              r_nxt.ptr = r.ptr + 8'h01; // see [RL10]
              r_nxt.oe_n = nb[7];
              r_nxt.st = D_TX;
            end else begin
              r_nxt.st = D_IDLE; // see [RL15]
            end
          end
        end
      endcase
    end
    // Axes are captured one after another; the sensor idles when done
    if (r.busy) begin
      if (r.tmr == 24'(MEAS_CYC - 1)) begin
        r_nxt.tmr = 24'h000000;
        r_nxt.axis = r.axis + 2'h1;
        unique case (r.axis)
          2'h0: begin
            r_nxt.res[1:0] = x_field; // see [RL14]
          end
          2'h1: begin
            r_nxt.res[3:2] = y_field;
          end
          default: begin
            r_nxt.res[5:4] = z_field;
            r_nxt.busy = 1'b0; // see [RL16]
            r_nxt.done = 1'b1; // see [RL13]
          end
        endcase
      end else begin
        r_nxt.tmr = r.tmr + 24'h000001;
      end
    end
    // A new trigger restarts acquisition even if one is running
    if (trig) begin
      r_nxt.busy = 1'b1; // see [RL12]
      r_nxt.done = 1'b0;
      r_nxt.axis = 2'h0;
      r_nxt.tmr = 24'h000000;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
      r.st <= D_IDLE;
      r.ptr <= PTR_RESET;
      r.oe_n <= 1'b1;
      r.scl_q <= 1'b1;
      r.sda_q <= 1'b1;
    end else begin
      r <= r_nxt;
    end
  end

  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe_n = r.oe_n;
  assign meas_active = r.busy;
  assign meas_done = r.done;
endmodule
`default_nettype wire

// ---- hw/mag_host.sv ----
// Host end: register-driven two-wire master for pointer writes and reads.
// Assumes the slave never stretches the clock; no arbitration is attempted.
`timescale 1ns/1ps
`default_nettype none
module mag_host
  import mag_pkg::*;
#(
  parameter int QTR = SCL_QTR_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic irq,
  mag_link_if.host link
);
  typedef enum logic [4:0] {
    H_IDLE = 5'b00001,
    H_START = 5'b00010,
    H_SEND = 5'b00100,
    H_RECV = 5'b01000,
    H_STOP = 5'b10000
  } hstate_t;

  typedef struct packed {
    hstate_t st;
    logic [6:0] slv;
    logic [7:0] ptr;
    logic rdop;
    logic [2:0] len;
    logic nack;
    logic [1:0] ist;
    logic [1:0] imask;
    logic [7:0][7:0] buff;
    logic [7:0] rdata;
    logic [1:0] step;
    logic [2:0] idx;
    logic [3:0] bitn;
    logic [1:0] ph;
    logic [7:0] qcnt;
    logic [7:0] sh;
    logic scl_oe_n;
    logic sda_oe_n;
    logic ack;
  } host_t;

  host_t r;
  host_t n;
  logic sda_s;
  logic tick;
  logic busy;

  bit_sync #(.W(1)) u_sync (
    .clk(clk),
    .rst(rst),
    .d(link.sda),
    .q(sda_s)
  );

  assign busy = (r.st != H_IDLE);
  assign tick = busy && (r.qcnt == 8'(QTR - 1));

  always_comb begin
    n = r;
    if (rd) begin
      n.rdata = 8'h00;
      unique case (addr)
        H_SLAVE: n.rdata = {1'b0, r.slv};
        H_PTR: n.rdata = r.ptr;
        H_CTRL: n.rdata = {1'b0, r.len, 2'b00, r.rdop, busy};
        H_STAT: n.rdata = {6'h00, r.nack, busy};
        H_IRQ_STAT: n.rdata = {6'h00, r.ist};
        H_IRQ_MASK: n.rdata = {6'h00, r.imask};
        default: if (addr[7:5] == H_BUF_PAGE) n.rdata = r.buff[addr[4:2]];
      endcase
    end
    if (wr) begin
      unique case (addr)
        H_SLAVE: n.slv = wdata[6:0];
        H_PTR: n.ptr = wdata;
        H_IRQ_STAT: n.ist = r.ist & ~wdata[1:0];
        H_IRQ_MASK: n.imask = wdata[1:0];
        H_CTRL: begin
          if (wdata[CTRL_GO] && !busy) begin
            n.rdop = wdata[CTRL_READ];
            n.len = wdata[CTRL_LEN_LSB +: 3];
            n.nack = 1'b0;
            n.st = H_START;
            n.step = 2'h0;
            n.ph = 2'h0;
            n.qcnt = 8'h00;
          end
        end
        default: if (addr[7:5] == H_BUF_PAGE) n.buff[addr[4:2]] = wdata;
      endcase
    end
    if (busy) begin
      n.qcnt = tick ? 8'h00 : r.qcnt + 8'h01;
    end
    if (tick) begin
      n.ph = r.ph + 2'h1;
      // Phase 0 moves data with clock low, 1 raises clock, 2 samples, 3 lowers
      if (r.ph == 2'h1) n.scl_oe_n = 1'b1;
      if (r.ph == 2'h3) n.scl_oe_n = 1'b0;
      unique case (r.st)
        H_START: begin
          // Clock follows the common phases: raised at 1, so data falls at 2 with clock high, also for a repeated start
          if (r.ph == 2'h0) begin
            n.sda_oe_n = 1'b1;
          end
          if (r.ph == 2'h2) n.sda_oe_n = 1'b0; // see [RL1]
          if (r.ph == 2'h3) begin
            n.st = H_SEND;
            n.bitn = 4'h0;
            n.sh = {r.slv, r.step == 2'h3}; // see [RL5]
          end
        end
        H_SEND: begin
          if (r.ph == 2'h0) n.sda_oe_n = (r.bitn == 4'h8) | r.sh[7]; // see [RL4]
          if (r.ph == 2'h2 && r.bitn == 4'h8) n.ack = ~sda_s; // see [RL3]
          if (r.ph == 2'h3) begin
            n.sh = {r.sh[6:0], 1'b0};
            n.bitn = r.bitn + 4'h1;
            if (r.bitn == 4'h8) begin
              n.bitn = 4'h0;
              if (!r.ack) begin
                n.nack = 1'b1;
                n.st = H_STOP;
              end else begin
                unique case (r.step)
                  2'h0: begin
                    n.step = 2'h1;
                    n.sh = r.ptr; // see [RL8]
                  end
                  2'h1: begin
                    n.idx = 3'h0;
                    n.step = r.rdop ? 2'h3 : 2'h2;
                    n.st = r.rdop ? H_START : H_SEND; // see [RL9]
                    n.sh = r.buff[0];
                  end
                  2'h2: begin
                    n.idx = r.idx + 3'h1;
                    n.sh = r.buff[r.idx + 3'h1];
                    if (r.idx == r.len) n.st = H_STOP;
                  end
                  2'h3: begin
                    n.st = H_RECV;
                  end
                endcase
              end
            end
          end
        end
        H_RECV: begin
          if (r.ph == 2'h0) n.sda_oe_n = (r.bitn != 4'h8) | (r.idx == r.len); // see [RL15]
          if (r.ph == 2'h2 && r.bitn != 4'h8) n.sh = {r.sh[6:0], sda_s};
          if (r.ph == 2'h3) begin
            n.bitn = r.bitn + 4'h1;
            if (r.bitn == 4'h7) n.buff[r.idx] = r.sh;
            if (r.bitn == 4'h8) begin
              n.bitn = 4'h0;
              n.idx = r.idx + 3'h1;
              if (r.idx == r.len) n.st = H_STOP; // see [RL15]
            end
          end
        end
        H_STOP: begin
          if (r.ph == 2'h0) n.sda_oe_n = 1'b0;
          if (r.ph == 2'h2) n.sda_oe_n = 1'b1; // see [RL2]
          if (r.ph == 2'h3) begin
            n.scl_oe_n = 1'b1;
            n.st = H_IDLE;
            n.ist[IRQ_DONE] = 1'b1;
            if (r.nack) n.ist[IRQ_NACK] = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
      r.st <= H_IDLE;
      r.slv <= H_SLAVE_RESET;
      r.scl_oe_n <= 1'b1;
      r.sda_oe_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign rdata = r.rdata;
  assign irq = |(r.ist & r.imask);
  assign link.host_scl_o = 1'b0;
  assign link.host_scl_oe_n = r.scl_oe_n;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe_n = r.sda_oe_n;
endmodule
`default_nettype wire

// ---- hw/mag_link_if.sv ----
// Two-wire link between the host end and the device end.
// Both lines are open drain with pull-ups; a low enable means driving low.
`timescale 1ns/1ps
`default_nettype none
interface mag_link_if;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;
  assign scl = host_scl_oe_n | host_scl_o;
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe_n,
    output host_sda_o, output host_sda_oe_n);
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
endinterface
`default_nettype wire

// ---- hw/mag_pkg.sv ----
// Constants shared by the magnetometer link device end and its host end.
// Assumes a single 50 MHz clock and synchronous active-high reset everywhere.
// Function
// [RL1] Start: data falls while clock high
// [RL2] Stop: data rises while clock high
// [RL3] Eight data bits plus one acknowledge bit
// [RL4] Every byte shifted most significant bit first
// [RL5] Seven-bit address then direction, one reads
// [RL6] Device address 0110 plus three strapped bits
// [RL7] Device acknowledges its address on ninth pulse
// [RL8] First written byte loads the register pointer
// [RL9] Then data writes or repeated start read
// [RL10] Pointer advances after every byte
// [RL11] Stop or new start ends the access
// [RL12] Writing bit zero to control starts measurement
// [RL13] Status bit zero flags results ready
// [RL14] Results from register zero, x y z low-high
// [RL15] Master acks reads, nacks last, then stops
// [RL16] Device powers down after acquisition ends
// [RL17] Master waits for measurement completion time; the bench polls status bit zero instead
// [RL18] Foreign address: stay released until next start
// [RL19] Read without pointer write uses current pointer
package mag_pkg;
  localparam int CLK_NS = 20;
  // Device address and register map
  localparam logic [3:0] DEV_ADDR_HI = 4'h6;
  localparam logic [7:0] REG_X_LO = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h06;
  localparam logic [7:0] REG_CONTROL = 8'h07;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam int BIT_DONE = 0;
  localparam int BIT_TRIGGER = 0;
  // Time spent acquiring each axis
  localparam int MEAS_AXIS_NS = 400000;
  localparam int MEAS_AXIS_CYC = (MEAS_AXIS_NS + CLK_NS - 1) / CLK_NS;
  // Host bus clock: one quarter of the bit time is the phase step
  localparam int SCL_NS = 2500;
  localparam int SCL_QTR_CYC = (SCL_NS / 4 + CLK_NS - 1) / CLK_NS;
  // Host command port map
  localparam logic [7:0] H_SLAVE = 8'h00;
  localparam logic [7:0] H_PTR = 8'h04;
  localparam logic [7:0] H_CTRL = 8'h08;
  localparam logic [7:0] H_STAT = 8'h0C;
  localparam logic [7:0] H_IRQ_STAT = 8'h10;
  localparam logic [7:0] H_IRQ_MASK = 8'h14;
  localparam logic [2:0] H_BUF_PAGE = 3'h1;
  localparam int CTRL_GO = 0;
  localparam int CTRL_READ = 1;
  localparam int CTRL_LEN_LSB = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_NACK = 1;
  localparam logic [6:0] H_SLAVE_RESET = 7'h30;
endpackage

// ---- verif/mag_assertions.sv ----
// Link checker: watches the resolved two-wire lines and both ends' data enables.
// Assumes one clock domain and a static address strap.
`timescale 1ns/1ps
`default_nettype none
module mag_assertions
  import mag_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_oe_n,
  input wire logic [2:0] addr_lo
);
  logic scl_q, sda_q, first, foreign, idle;
  logic [3:0] cnt;
  logic [7:0] sh;
  logic start_ev, stop_ev, rise, mine;
  assign start_ev = scl && scl_q && sda_q && !sda;
  assign stop_ev = scl && scl_q && !sda_q && sda;
  assign rise = scl && !scl_q;
  assign mine = (sh[7:1] == {DEV_ADDR_HI, addr_lo});
  // Bit count restarts at every start or stop so framing slips show up at once
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sh <= 8'h00;
      cnt <= 4'h0;
      first <= 1'b0;
      foreign <= 1'b0;
      idle <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (rise) sh <= {sh[6:0], sda};
      if (start_ev || stop_ev) cnt <= 4'h0;
      else if (rise) cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
      if (start_ev) first <= 1'b1;
      else if (rise && cnt == 4'h8) first <= 1'b0;
      if (start_ev) foreign <= 1'b0;
      else if (rise && cnt == 4'h8 && first && !mine) foreign <= 1'b1;
      if (stop_ev) idle <= 1'b1;
      else if (start_ev) idle <= 1'b0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence ack_s;
    rise && cnt == 4'h8;
  endsequence
  sequence addr_ack_s;
    ack_s ##0 (first && mine);
  endsequence
  AST_ADDR_ACK: assert property (addr_ack_s |-> !dev_sda_oe_n [*2])
    else $error("device did not acknowledge its address");
  AST_FOREIGN_ACK: assert property ((ack_s ##0 (first && !mine)) |-> dev_sda_oe_n)
    else $error("device acknowledged a foreign address");
  AST_FOREIGN_QUIET: assert property (foreign |-> dev_sda_oe_n)
    else $error("device drove data after a foreign address");
  AST_ONE_DRIVER: assert property (ack_s |-> (host_sda_oe_n || dev_sda_oe_n))
    else $error("both ends drive data in the acknowledge slot");
  AST_ADDR_FROM_HOST: assert property ((first && scl && cnt < 4'h8) |-> dev_sda_oe_n)
    else $error("device drove data during the address byte");
  AST_DEV_SCL_LOW: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("device changed data while the clock was high");
  AST_STOP_FRAMING: assert property (stop_ev |-> cnt == 4'h1)
    else $error("stop not on a nine-bit boundary");
  AST_START_FRAMING: assert property (start_ev |-> cnt <= 4'h1)
    else $error("start not on a nine-bit boundary");
  AST_IDLE_SCL: assert property (idle |-> scl)
    else $error("clock low while the link is idle");
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// Bench: the host end talks to the device end over the link interface.
// Assumes the host command map of the hand-over and a static strap.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mag_pkg::*;
  localparam int MEAS = 200;
  localparam int LIMIT = 60000;
  logic clk, rst, wr, rd, irq, meas_active, meas_done, model_done;
  logic [7:0] addr, wdata, rdata, v, mon_sh;
  logic [2:0] addr_lo;
  logic [15:0] fx, fy, fz;
  logic [6:0] slave;
  logic scl_q, sda_q, mon_first;
  logic [7:0] mon_q[$];
  int mon_n, mismatches, checks_done, cycles, k;
  mag_link_if link_if();
  mag_device #(.MEAS_CYC(MEAS)) mag_device_inst (.clk(clk), .rst(rst), .link(link_if.dev),
    .addr_lo(addr_lo), .x_field(fx), .y_field(fy), .z_field(fz),
    .meas_active(meas_active), .meas_done(meas_done));
  mag_host #(.QTR(4)) mag_host_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .link(link_if.host));
  mag_assertions mag_assertions_inst (.clk(clk), .rst(rst), .scl(link_if.scl),
    .sda(link_if.sda), .host_sda_oe_n(link_if.host_sda_oe_n),
    .dev_sda_oe_n(link_if.dev_sda_oe_n), .addr_lo(addr_lo));
  function automatic logic [7:0] dev_byte(input int p);
    logic [47:0] res;
    res = {fz, fy, fx};
    if (p < 6) return res[p*8 +: 8];
    if (p == 6) return {7'h00, model_done};
    return 8'h00;
  endfunction
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // One link transfer: pointer, then buffered data or a repeated-start read
  task xfer(input logic [7:0] ptr, input logic rdir, input int n);
    logic [7:0] s;
    mon_q.delete();
    wr_reg(H_PTR, ptr);
    wr_reg(H_CTRL, {1'b0, 3'(n - 1), 2'b00, rdir, 1'b1});
    for (int i = 0; i < 4000; i++) begin
      rd_reg(H_STAT, s);
      if (s[0] === 1'b0) break;
    end
    check("host idle", s[0], 16'h0000);
    check("address count", 16'(mon_q.size()), rdir ? 16'h0002 : 16'h0001);
    check("write address", mon_q[0], {slave, 1'b0});
    if (rdir) check("read address", mon_q[1], {slave, 1'b1});
  endtask
  // Captures the first byte after every start straight off the wires
  always @(posedge clk) begin
    scl_q <= link_if.scl;
    sda_q <= link_if.sda;
    if (scl_q && link_if.scl && sda_q && !link_if.sda) begin
      mon_n = 0;
      mon_first = 1'b1;
    end else if (!scl_q && link_if.scl) begin
      mon_sh = {mon_sh[6:0], link_if.sda};
      mon_n++;
      if (mon_n == 8 && mon_first) begin
        mon_q.push_back(mon_sh);
        mon_first = 1'b0;
      end
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      results();
    end
  end
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {rst, wr, rd, addr, wdata, model_done, scl_q, sda_q, mon_first} = {1'b1, 19'h0, 3'h6};
    {mon_sh, mon_n, mismatches, checks_done, cycles} = 0;
    k = $urandom(32'h6361);
    addr_lo = 3'($urandom());
    fx = 16'($urandom());
    fy = 16'($urandom());
    fz = 16'($urandom());
    slave = {DEV_ADDR_HI, addr_lo};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_reg(H_SLAVE, v);
    check("slave reset", v, {1'b0, H_SLAVE_RESET});
    rd_reg(8'h18, v);
    check("unmapped read", v, 16'h0000);
    check("meas reset", {meas_active, meas_done, irq}, 16'h0000);
    wr_reg(H_SLAVE, {1'b0, slave});
    wr_reg(H_IRQ_MASK, 8'h03);
    wr_reg(8'h20, 8'hFE);
    xfer(REG_CONTROL, 1'b0, 1);
    check("no trigger", {meas_active, meas_done}, 16'h0000);
    settle();
    check("irq done", irq, 16'h0001);
    wr_reg(H_IRQ_STAT, 8'h03);
    settle();
    check("irq cleared", irq, 16'h0000);
    wr_reg(8'h20, 8'h01);
    xfer(REG_CONTROL, 1'b0, 1);
    check("acquiring", {meas_active, meas_done}, 16'h0002);
    model_done = 1'b1;
    // Poll until completion rather than trusting a fixed wait
    for (k = 0; k < 20; k++) begin
      xfer(REG_STATUS, 1'b1, 1);
      rd_reg(8'h20, v);
      if (v[0] === 1'b1) break;
    end
    check("status done", v, dev_byte(6));
    check("powered down", {meas_active, meas_done}, 16'h0001);
    xfer(REG_X_LO, 1'b1, 8);
    for (int i = 0; i < 8; i++) begin
      rd_reg(8'(32 + 4 * i), v);
      check("burst byte", v, dev_byte(i));
    end
    wr_reg(8'h20, 8'($urandom()));
    wr_reg(8'h24, 8'($urandom()));
    wr_reg(8'h28, 8'h01);
    xfer(8'h05, 1'b0, 3);
    check("restart", {meas_active, meas_done}, 16'h0002);
    for (k = 0; k < 2000; k++) begin
      @(posedge clk);
      if (meas_done === 1'b1) break;
    end
    check("restart done", {meas_active, meas_done}, 16'h0001);
    wr_reg(H_IRQ_STAT, 8'h03);
    wr_reg(H_IRQ_MASK, 8'h00);
    wr_reg(8'h20, 8'h01);
    for (int j = 0; j < 2; j++) begin
      slave = (j == 0) ? {DEV_ADDR_HI, addr_lo ^ 3'h5} : {4'h7, addr_lo};
      wr_reg(H_SLAVE, {1'b0, slave});
      xfer(REG_CONTROL, 1'b0, 1);
      rd_reg(H_STAT, v);
      check("nack flag", v[1], 16'h0001);
      check("still done", {meas_active, meas_done}, 16'h0001);
    end
    rd_reg(H_IRQ_STAT, v);
    check("irq status", v, 16'h0003);
    check("irq masked", irq, 16'h0000);
    wr_reg(H_IRQ_MASK, 8'h02);
    settle();
    check("irq nack", irq, 16'h0001);
    wr_reg(H_IRQ_STAT, 8'h02);
    settle();
    check("irq nack cleared", irq, 16'h0000);
    results();
  end
endmodule
`default_nettype wire
